/* File: inc/gdi_pkg.sv */
// Purpose: Constants for the general-purpose pin direction and input block
// Assumes: 32-bit AXI4-Lite register bus, byte address = 4 * register index
// Notes:   Printed offsets are not word aligned, so they are kept as indices
package gdi_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W          = 12;
  localparam logic [7:0]  IDX_ALT_SELECT  = 8'h4F;
  localparam logic [7:0]  IDX_OUT_VALUE   = 8'h50;
  localparam logic [7:0]  IDX_DIRECTION   = 8'h51;
  localparam logic [7:0]  IDX_INPUT_LEVEL = 8'h52;
  localparam logic [ADDR_W-1:0] A_ALT_SELECT  = {2'h0, IDX_ALT_SELECT,  2'h0};
  localparam logic [ADDR_W-1:0] A_OUT_VALUE   = {2'h0, IDX_OUT_VALUE,   2'h0};
  localparam logic [ADDR_W-1:0] A_DIRECTION   = {2'h0, IDX_DIRECTION,   2'h0};
  localparam logic [ADDR_W-1:0] A_INPUT_LEVEL = {2'h0, IDX_INPUT_LEVEL, 2'h0};

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  PIN_MASK        = 8'hFD; // Bit 1 is no general pin
  localparam logic [7:0]  ALT_MASK        = 8'hC0;
  localparam logic [7:0]  DIR_RST         = 8'hFF; // All pins inputs
  localparam logic [7:0]  OUT_RST         = 8'h00;
  localparam logic [7:0]  ALT_RST         = 8'h00;
  localparam logic [7:0]  IN_RST          = 8'h00;
  localparam int unsigned BIT_RSVD        = 1;
  localparam int unsigned BIT_IRQ_PIN     = 7;
  localparam int unsigned BIT_RSVD_ALT    = 6;
  localparam int unsigned BIT_SYNC_PIN    = 5;
  localparam int unsigned BIT_IRQ_SEL     = 7;
  localparam int unsigned BIT_SYNC_SEL    = 6;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

/* File: verilog/gdi_gpio.sv */
// Purpose: Direction control and input sampling for pins 7..2 and 0
// Assumes: One 40 MHz clock, synchronous active-high reset, AXI4-Lite host
// Notes:   Pin 1 is never driven here; it belongs to another block
//
// Overview of operation
// - Direction bit 0 drives pin, 1 leaves input
// - Direction register resets to all ones
// - Direction register read/write; bit 1 reserved
// - Input register returns synchronised pin levels
// - Input bit 1 zero; writes ignored
// - Output pins drive the output-data register bit
// - Alternate select takes pins for irq, sync
`timescale 1ns/1ps

module gdi_gpio
  import gdi_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              srst,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Alternate function sources
  input  wire logic              host_irq_out,
  input  wire logic              packet_sync_out,
  // Pins
  input  wire logic [7:0]        pin_in,
  output logic [7:0]             pin_out,
  output logic [7:0]             pin_oe_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]        dir_r;
  logic [7:0]        out_r;
  logic [7:0]        alt_r;
  logic [7:0]        in_meta_r;
  logic [7:0]        in_sync_r;
  logic              aw_held_r;
  logic              w_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0]        w_data_r;
  logic              w_lane_r;
  logic              wr_go;
  logic              wr_hit;
  logic [7:0]        pin_out_nxt;
  logic [7:0]        pin_oe_n_nxt;

  // ----------------------------------------------------------------
  // Write channels: address and data taken in either order
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_hit        = (aw_addr_r == A_ALT_SELECT) || (aw_addr_r == A_OUT_VALUE)
                      || (aw_addr_r == A_DIRECTION) || (aw_addr_r == A_INPUT_LEVEL);

  // Latch address
  always_ff @(posedge clock) begin
    if (srst) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  // Latch data; only byte lane 0 carries register bits
  always_ff @(posedge clock) begin
    if (srst) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_lane_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata[7:0];
      w_lane_r <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  // Response one edge after both halves are held
  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  // Reserved bit 1 is held at its reset value so it steers nothing
  always_ff @(posedge clock) begin
    if (srst) begin
      dir_r <= DIR_RST;
    end else if (wr_go && w_lane_r && aw_addr_r == A_DIRECTION) begin
      dir_r <= (w_data_r & PIN_MASK) | (DIR_RST & ~PIN_MASK);
    end
  end

  // Output values
  always_ff @(posedge clock) begin
    if (srst) begin
      out_r <= OUT_RST;
    end else if (wr_go && w_lane_r && aw_addr_r == A_OUT_VALUE) begin
      out_r <= w_data_r & PIN_MASK;
    end
  end

  // Alternate function selects
  always_ff @(posedge clock) begin
    if (srst) begin
      alt_r <= ALT_RST;
    end else if (wr_go && w_lane_r && aw_addr_r == A_ALT_SELECT) begin
      alt_r <= w_data_r & ALT_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  // Samples the pad, so a driven pin reads back its own level
  always_ff @(posedge clock) begin
    if (srst) begin
      in_meta_r <= IN_RST;
      in_sync_r <= IN_RST;
    end else begin
      in_meta_r <= pin_in;
      in_sync_r <= in_meta_r & PIN_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Data answered one edge after the address is taken
  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        A_ALT_SELECT:  s_axi_rdata <= {24'h000000, alt_r};
        A_OUT_VALUE:   s_axi_rdata <= {24'h000000, out_r};
        A_DIRECTION:   s_axi_rdata <= {24'h000000, dir_r};
        A_INPUT_LEVEL: s_axi_rdata <= {24'h000000, in_sync_r};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Alternate functions override direction; pin 1 never driven
  always_comb begin
    pin_out_nxt  = out_r & PIN_MASK;
    pin_oe_n_nxt = dir_r | ~PIN_MASK;
    if (alt_r[BIT_IRQ_SEL]) begin
      pin_out_nxt[BIT_IRQ_PIN]  = host_irq_out;
      pin_oe_n_nxt[BIT_IRQ_PIN] = 1'b0;
    end
    if (alt_r[BIT_SYNC_SEL]) begin
      pin_out_nxt[BIT_SYNC_PIN]  = packet_sync_out;
      pin_oe_n_nxt[BIT_SYNC_PIN] = 1'b0;
      pin_out_nxt[BIT_RSVD_ALT]  = 1'b0;
      pin_oe_n_nxt[BIT_RSVD_ALT] = 1'b1;
    end
  end

  // Registered pads avoid glitches on the board
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_out  <= OUT_RST;
      pin_oe_n <= DIR_RST;
    end else begin
      pin_out  <= pin_out_nxt;
      pin_oe_n <= pin_oe_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_dir_reset;
    @(posedge clock) $past(srst) |-> dir_r == DIR_RST && pin_oe_n == DIR_RST;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not all inputs after reset");

  property p_plain_dir;
    @(posedge clock) disable iff (srst) !$past(srst) |-> pin_oe_n[4:0] == ($past(dir_r[4:0]) | 5'h02);
  endproperty
  a_plain_dir: assert property (p_plain_dir) else $error("pin enable does not follow direction");

  property p_dir_write;
    @(posedge clock) disable iff (srst)
      wr_go && w_lane_r && aw_addr_r == A_DIRECTION |=> dir_r == ($past(w_data_r) | 8'h02) ##1 pin_oe_n[1] == 1'b1;
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost or bit 1 changed");

  property p_in_read;
    @(posedge clock) disable iff (srst)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == A_INPUT_LEVEL
      |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(in_sync_r)};
  endproperty
  a_in_read: assert property (p_in_read) else $error("input read returns wrong level");

  property p_in_rsvd;
    @(posedge clock) disable iff (srst) s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && !in_sync_r[BIT_RSVD];
  endproperty
  a_in_rsvd: assert property (p_in_rsvd) else $error("reserved input bits not zero");

  property p_out_value;
    @(posedge clock) disable iff (srst) !$past(srst) |-> pin_out[4:2] == $past(out_r[4:2]);
  endproperty
  a_out_value: assert property (p_out_value) else $error("pin value differs from output register");

  property p_alt_irq;
    @(posedge clock) disable iff (srst)
      !$past(srst) && $past(alt_r[BIT_IRQ_SEL]) |-> !pin_oe_n[BIT_IRQ_PIN] && pin_out[BIT_IRQ_PIN] == $past(host_irq_out);
  endproperty
  a_alt_irq: assert property (p_alt_irq) else $error("irq alternate function not on pin 7");

  property p_sync2;
    @(posedge clock) disable iff (srst) !$past(srst) && !$past(srst, 2) |-> in_sync_r == ($past(pin_in, 2) & PIN_MASK);
  endproperty
  a_sync2: assert property (p_sync2) else $error("input not seen two edges later");

  property p_cov_drive;
    @(posedge clock) disable iff (srst) $fell(pin_oe_n[0]);
  endproperty
  c_cov_drive: cover property (p_cov_drive);

  property p_cov_read;
    @(posedge clock) disable iff (srst) s_axi_rvalid && s_axi_rready;
  endproperty
  c_cov_read: cover property (p_cov_read);

  property p_cov_sync_alt;
    @(posedge clock) disable iff (srst) alt_r[BIT_SYNC_SEL] && !pin_oe_n[BIT_SYNC_PIN];
  endproperty
  c_cov_sync_alt: cover property (p_cov_sync_alt);

endmodule // gdi_gpio

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the pin direction and input block
// Assumes: Bus answers within a few cycles; bready and rready stay high
// Notes:   Pins are checked at the falling edge, once register updates land
`timescale 1ns/1ps

module tb_top
  import gdi_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic              clock = 1'b0;
  logic              srst  = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              host_irq_out = 1'b0, packet_sync_out = 1'b0;
  logic [7:0]        pin_in = 8'h00, pin_out, pin_oe_n;
  int                err_total = 0, compares = 0;

  always #12.5 clock = ~clock;

  // Ready lines held high, so every answer is taken at once
  gdi_gpio uut (
    .clock(clock), .srst(srst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
    .host_irq_out(host_irq_out), .packet_sync_out(packet_sync_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit got;
    n = 0;
    got = 0;
    r = 2'h3;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    while (!got && n < 50) begin
      @(posedge clock);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        got = 1;
        r   = s_axi_bresp;
      end
    end
    if (!got) chk(32'h0, 32'h1);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit got;
    n = 0;
    got = 0;
    d = 'x;
    r = 2'h3;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    while (!got && n < 50) begin
      @(posedge clock);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        got = 1;
        d   = s_axi_rdata;
        r   = s_axi_rresp;
      end
    end
    if (!got) chk(32'h0, 32'h1);
  endtask

  // Register to pin takes one edge; a second gives margin
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    settle(1);
    chk({24'h0, pin_oe_n}, 32'h0000_00FF);
    rd(A_DIRECTION, d, r);
    chk(d, 32'h0000_00FF);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(A_INPUT_LEVEL, d, r);
    chk(d, 32'h0000_0000);
  endtask

  // Bit 1 keeps reading one and never enables pin 1
  task automatic t_direction();
    logic [31:0] d;
    logic [1:0]  r;
    wr(A_DIRECTION, 32'h0000_0000, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(A_DIRECTION, d, r);
    chk(d, 32'h0000_0002);
    settle(2);
    chk({24'h0, pin_oe_n}, 32'h0000_0002);
    wr(A_DIRECTION, 32'h0000_00F0, r);
    settle(2);
    chk({24'h0, pin_oe_n}, 32'h0000_00F2);
  endtask

  // Only pins 3, 2 and 0 are outputs here
  task automatic t_output();
    logic [31:0] d;
    logic [1:0]  r;
    wr(A_OUT_VALUE, 32'h0000_00FF, r);
    rd(A_OUT_VALUE, d, r);
    chk(d, 32'h0000_00FD);
    settle(2);
    chk({24'h0, pin_out & ~pin_oe_n}, 32'h0000_000D);
    chk({24'h0, pin_out}, 32'h0000_00FD);
  endtask

  // Levels seen on output pins too; pin 1 level masked out
  task automatic t_input();
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clock);
    pin_in <= 8'hA7;
    settle(4);
    rd(A_INPUT_LEVEL, d, r);
    chk(d, 32'h0000_00A5);
    wr(A_INPUT_LEVEL, 32'h0000_0000, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(A_INPUT_LEVEL, d, r);
    chk(d, 32'h0000_00A5);
  endtask

  // Alternate sources win over the direction register
  task automatic t_alt();
    logic [1:0] r;
    wr(A_DIRECTION, 32'h0000_00FF, r);
    host_irq_out    <= 1'b1;
    packet_sync_out <= 1'b1;
    wr(A_ALT_SELECT, 32'h0000_00C0, r);
    settle(2);
    chk({24'h0, pin_oe_n}, 32'h0000_005F);
    chk({30'h0, pin_out[7], pin_out[5]}, 32'h0000_0003);
    @(posedge clock);
    host_irq_out    <= 1'b0;
    packet_sync_out <= 1'b0;
    settle(2);
    chk({30'h0, pin_out[7], pin_out[5]}, 32'h0000_0000);
    wr(A_ALT_SELECT, 32'h0000_0000, r);
    settle(2);
    chk({24'h0, pin_oe_n}, 32'h0000_00FF);
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    rd(12'h200, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0000_0000);
    wr(12'h200, 32'h0000_0055, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_direction();
    t_output();
    t_input();
    t_alt();
    t_unmapped();
    complete_run();
  end

  // Tests need about a hundred cycles; 4000 is ample
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule // tb_top
